// >>> hw/dma_write_context_status.sv
// Write-side transfer context sets with read-only status view over AXI4-Lite
//
// Overview of operation
// - One context set per index, zero to one less than the depth parameter, one per queued request.
// - All context registers are read-only; bus writes never disturb tracked state.
// - Source address, source array reference and low stride half always read zero.
// - Count register upper half reports arrays still to be written.
// - Count register lower half reports bytes left in the current array.
// - Write address tracks destination; at completion holds last issued command address.
// - Stride register upper half holds byte offset between destination array starts.
// - Proxy bit 8 captures requester privilege at submission: 0 user, 1 supervisor.
// - Proxy bits 3-0 capture requester host identifier at submission.
// - Captured privilege and host identifier accompany every issued command.
// - Reload register keeps the programmed byte count, restoring it after each array.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dma_write_context_status #(
    parameter int DEPTH = wctx_pkg::DEF_DEPTH,
    parameter logic [15:0] CHUNK = wctx_pkg::DEF_CHUNK
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite register port
    input wire logic [wctx_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [wctx_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transfer request submission
    input wire logic sub_valid,
    output logic sub_ready,
    input wire logic [15:0] sub_arrays,
    input wire logic [15:0] sub_bytes,
    input wire logic [31:0] sub_addr,
    input wire logic [15:0] sub_stride,
    input wire logic sub_requester_privilege_level,
    input wire logic [wctx_pkg::HID_W-1:0] sub_host_id,
    // Write command issue
    output logic cmd_valid,
    input wire logic cmd_ready,
    output logic [31:0] cmd_addr,
    output logic [15:0] cmd_len,
    output logic cmd_requester_privilege_level,
    output logic [wctx_pkg::HID_W-1:0] cmd_host_id,
    input wire logic wr_done,
    output logic req_done
);
    import wctx_pkg::*;

    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic ctx_hit(input logic [AXI_AW-1:0] a);
        return (32'(a[AXI_AW-1:SET_LSB]) < DEPTH) && (a[SET_LSB-1:WORD_LSB] <= W_SBREF);
    endfunction

    function automatic logic [IW-1:0] inc_ptr(input logic [IW-1:0] p);
        return (32'(p) == DEPTH - 1) ? '0 : IW'(p + 1'b1);
    endfunction

    // ************************************************************
    // Context storage
    // ************************************************************
    logic [15:0] arrays_q [DEPTH];
    logic [15:0] bytes_q [DEPTH];
    logic [31:0] addr_q [DEPTH];
    logic [31:0] base_q [DEPTH];
    logic [15:0] stride_q [DEPTH];
    logic [15:0] reload_q [DEPTH];
    logic requester_privilege_level_q [DEPTH];
    logic [HID_W-1:0] hid_q [DEPTH];

    logic [IW-1:0] head_q;
    logic [IW-1:0] tail_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic run_q;
    eng_state_type state_q;

    logic cmd_valid_q;
    logic [31:0] cmd_addr_q;
    logic [15:0] cmd_len_q;
    logic cmd_requester_privilege_level_q;
    logic [HID_W-1:0] cmd_hid_q;
    logic req_done_q;
    logic sub_ready_q;

    // ************************************************************
    // Active context and its next step
    // ************************************************************
    wire logic [15:0] h_arr = arrays_q[head_q];
    wire logic [15:0] h_bytes = bytes_q[head_q];
    wire logic [31:0] h_addr = addr_q[head_q];
    wire logic [31:0] h_base = base_q[head_q];
    wire logic [15:0] h_stride = stride_q[head_q];
    wire logic [15:0] h_rld = reload_q[head_q];
    wire logic h_requester_privilege_level = requester_privilege_level_q[head_q];
    wire logic [HID_W-1:0] h_hid = hid_q[head_q];

    logic [15:0] s_len;
    logic [15:0] s_nbytes;
    logic [15:0] s_narr;
    logic [31:0] s_naddr;
    logic [31:0] s_nbase;
    logic s_array_end;
    logic s_last;

    wctx_step u_step (
        .bytes(h_bytes),
        .arrays(h_arr),
        .addr(h_addr),
        .base(h_base),
        .stride(h_stride),
        .reload(h_rld),
        .chunk(CHUNK),
        .len(s_len),
        .nbytes(s_nbytes),
        .narrays(s_narr),
        .naddr(s_naddr),
        .nbase(s_nbase),
        .array_end(s_array_end),
        .last(s_last)
    );

    wire logic pend_w = run_q && (count_q != '0) && (state_q == ST_IDLE);
    wire logic empty_h = (h_arr == '0) || (h_bytes == '0);
    wire logic start_w = pend_w && !empty_h;
    wire logic skip_w = pend_w && empty_h;
    wire logic step_w = (state_q == ST_WAIT) && wr_done;
    wire logic retire_w = skip_w || (step_w && s_last);
    wire logic sub_take = sub_valid && sub_ready_q;

    assign count_d = CW'(count_q + CW'(sub_take) - CW'(retire_w));

    // ************************************************************
    // Queue pointers and submission
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            head_q <= '0;
            tail_q <= '0;
            count_q <= '0;
            sub_ready_q <= 1'b0;
        end else begin
            if (retire_w) head_q <= inc_ptr(head_q);
            if (sub_take) tail_q <= inc_ptr(tail_q);
            count_q <= count_d;
            sub_ready_q <= 32'(count_d) < DEPTH;
        end
    end

    // Contexts change only by submission or engine progress, never by the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                arrays_q[i] <= '0;
                bytes_q[i] <= '0;
                addr_q[i] <= '0;
                base_q[i] <= '0;
                stride_q[i] <= '0;
                reload_q[i] <= '0;
                requester_privilege_level_q[i] <= 1'b0;
                hid_q[i] <= '0;
            end
        end else begin
            if (step_w) begin
                bytes_q[head_q] <= s_nbytes;
                arrays_q[head_q] <= s_narr;
                addr_q[head_q] <= s_naddr;
                base_q[head_q] <= s_nbase;
            end
            if (sub_take) begin
                arrays_q[tail_q] <= sub_arrays;
                bytes_q[tail_q] <= sub_bytes;
                addr_q[tail_q] <= sub_addr;
                base_q[tail_q] <= sub_addr;
                stride_q[tail_q] <= sub_stride;
                reload_q[tail_q] <= sub_bytes;
                requester_privilege_level_q[tail_q] <= sub_requester_privilege_level;
                hid_q[tail_q] <= sub_host_id;
            end
        end
    end

    // ************************************************************
    // Write command engine
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            cmd_valid_q <= 1'b0;
            cmd_addr_q <= '0;
            cmd_len_q <= '0;
            cmd_requester_privilege_level_q <= 1'b0;
            cmd_hid_q <= '0;
            req_done_q <= 1'b0;
        end else begin
            req_done_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_w) begin
                        cmd_valid_q <= 1'b1;
                        cmd_addr_q <= h_addr;
                        cmd_len_q <= s_len;
                        cmd_requester_privilege_level_q <= h_requester_privilege_level;
                        cmd_hid_q <= h_hid;
                        state_q <= ST_ISSUE;
                    end else if (skip_w) begin
                        req_done_q <= 1'b1;
                    end
                end
                ST_ISSUE: begin
                    if (cmd_ready) begin
                        cmd_valid_q <= 1'b0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wr_done) begin
                        req_done_q <= s_last;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Register decode
    // ************************************************************
    logic [AXI_AW-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_take;
    logic [AXI_AW-1:0] rd_addr;
    logic rd_take;

    wire logic [2:0] rd_word = rd_addr[SET_LSB-1:WORD_LSB];
    wire logic [IW-1:0] rd_idx = IW'(rd_addr[AXI_AW-1:SET_LSB]);
    wire logic rd_ctx = ctx_hit(rd_addr);
    wire logic rd_ctrl = (rd_addr == CTRL_ADDR);
    wire logic rd_stat = (rd_addr == STAT_ADDR);
    wire logic wr_ctx = ctx_hit(wr_addr);
    wire logic wr_ctrl = (wr_addr == CTRL_ADDR);
    wire logic wr_err = !(wr_ctx || wr_ctrl || (wr_addr == STAT_ADDR));
    wire logic rd_err = !(rd_ctx || rd_ctrl || rd_stat);

    wire logic [15:0] rd_arr_w = arrays_q[rd_idx];
    wire logic [15:0] rd_bytes_w = bytes_q[rd_idx];
    wire logic [31:0] cnt_word = (32'(rd_arr_w) << ARR_LSB) | 32'(rd_bytes_w);
    wire logic [31:0] bidx_word = 32'(stride_q[rd_idx]) << STRIDE_LSB;
    wire logic [31:0] prxy_word = (32'(requester_privilege_level_q[rd_idx]) << REQUESTER_PRIVILEGE_LEVEL_BIT) | 32'(hid_q[rd_idx]);
    wire logic [31:0] ctrl_word = 32'(run_q) << RUN_BIT;
    wire logic [31:0] stat_word = (32'(state_q != ST_IDLE) << BUSY_BIT) | 32'(count_q);

    // Source-side words and the low stride half fall through to zero
    wire logic [31:0] ctx_word =
        (rd_word == W_CNT) ? cnt_word :
        (rd_word == W_DST) ? addr_q[rd_idx] :
        (rd_word == W_BIDX) ? bidx_word :
        (rd_word == W_PRXY) ? prxy_word :
        (rd_word == W_RLD) ? 32'(reload_q[rd_idx]) : '0;
    wire logic [31:0] rd_data =
        rd_ctx ? ctx_word :
        rd_ctrl ? ctrl_word :
        rd_stat ? stat_word : '0;

    // Only the engine run bit accepts writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= CTRL_RUN_RST;
        end else if (wr_take && wr_ctrl && wr_strb[0]) begin
            run_q <= wr_data[RUN_BIT];
        end
    end

    wctx_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_take(wr_take),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_take(rd_take),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    assign sub_ready = sub_ready_q;
    assign cmd_valid = cmd_valid_q;
    assign cmd_addr = cmd_addr_q;
    assign cmd_len = cmd_len_q;
    assign cmd_requester_privilege_level = cmd_requester_privilege_level_q;
    assign cmd_host_id = cmd_hid_q;
    assign req_done = req_done_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence launch_s;
        start_w ##1 cmd_valid_q;
    endsequence

    sequence chunk_s;
        step_w && !s_array_end;
    endsequence

    sequence next_array_s;
        step_w && s_array_end && !s_last;
    endsequence

    depth_bound_a: assert property (
        (32'(count_q) <= DEPTH) && ((32'(count_q) != DEPTH) || !sub_ready_q))
        else $error("context queue exceeds depth");

    bus_write_ro_a: assert property (
        wr_take && wr_ctx && !step_w && !sub_take && !retire_w
        |=> $stable(h_arr) && $stable(h_bytes) && $stable(h_addr))
        else $error("bus write altered context");

    src_zero_a: assert property (
        rd_take && rd_ctx && (rd_word == W_SRC || rd_word == W_SBREF)
        |=> s_axi_rvalid && (s_axi_rdata == '0))
        else $error("source field not zero");

    stride_low_a: assert property (
        rd_take && rd_ctx && (rd_word == W_BIDX) |=> s_axi_rdata[CNT_W-1:0] == '0)
        else $error("source stride not zero");

    count_read_a: assert property (
        rd_take && rd_ctx && (rd_word == W_CNT)
        |=> (s_axi_rdata[ARR_LSB+:CNT_W] == $past(rd_arr_w))
            && (s_axi_rdata[CNT_W-1:0] == $past(rd_bytes_w)))
        else $error("count read mismatch");

    byte_step_a: assert property (
        chunk_s |=> h_bytes == 16'($past(h_bytes) - $past(s_len)))
        else $error("byte count not decremented");

    cmd_addr_a: assert property (
        launch_s |-> (cmd_addr_q == $past(h_addr)) && (cmd_len_q == $past(s_len)))
        else $error("command address wrong");

    final_addr_a: assert property (
        step_w && s_last |=> addr_q[$past(head_q)] == $past(cmd_addr_q))
        else $error("final address not last command");

    next_array_a: assert property (
        next_array_s |=> (h_addr == $past(h_base) + {16'h0000, $past(h_stride)})
            && (h_arr == $past(h_arr) - 16'h0001))
        else $error("array advance wrong");

    requester_privilege_level_cap_a: assert property (
        sub_take |=> requester_privilege_level_q[$past(tail_q)] == $past(sub_requester_privilege_level))
        else $error("privilege not captured");

    host_cap_a: assert property (
        sub_take |=> hid_q[$past(tail_q)] == $past(sub_host_id))
        else $error("host id not captured");

    cmd_tag_a: assert property (
        cmd_valid_q |-> (cmd_requester_privilege_level_q == h_requester_privilege_level) && (cmd_hid_q == h_hid))
        else $error("command lacks requester tags");

    reload_a: assert property (
        next_array_s |=> h_bytes == $past(h_rld))
        else $error("byte count not reloaded");

    issue_wait_a: assert property (
        cmd_valid_q && cmd_ready |=> (state_q == ST_WAIT) && !cmd_valid_q [*1])
        else $error("command not retired to wait");
endmodule // dma_write_context_status
`default_nettype wire

// >>> hw/wctx_axil.sv
// AXI4-Lite slave handshakes for the write context registers
`timescale 1ns/1ps
`default_nettype none
module wctx_axil (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite
    input wire logic [wctx_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [wctx_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register file side
    output logic [wctx_pkg::AXI_AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    output logic wr_take,
    input wire logic wr_err,
    output logic [wctx_pkg::AXI_AW-1:0] rd_addr,
    output logic rd_take,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    import wctx_pkg::*;
    logic aw_got_q;
    logic w_got_q;
    assign wr_take = aw_got_q && w_got_q && !bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_got_q <= 1'b1;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_got_q <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_take) begin
                bvalid <= 1'b1;
                bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rd_take <= 1'b0;
            rd_addr <= '0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            rd_take <= arvalid && arready;
            if (arvalid && arready) begin
                arready <= 1'b0;
                rd_addr <= araddr;
            end
            if (rd_take) begin
                rvalid <= 1'b1;
                rdata <= rd_data;
                rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule // wctx_axil
`default_nettype wire

// >>> hw/wctx_pkg.sv
// Constants and types shared by the write context status block
package wctx_pkg;
    localparam int AXI_AW = 12;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int HID_W = 4;
    localparam int DEF_DEPTH = 4;
    localparam logic [15:0] DEF_CHUNK = 16'h0040;
    // Address layout: one set of eight words per context index
    localparam int SET_LSB = 5;
    localparam int WORD_LSB = 2;
    localparam logic [2:0] W_SRC = 3'h0;
    localparam logic [2:0] W_CNT = 3'h1;
    localparam logic [2:0] W_DST = 3'h2;
    localparam logic [2:0] W_BIDX = 3'h3;
    localparam logic [2:0] W_PRXY = 3'h4;
    localparam logic [2:0] W_RLD = 3'h5;
    localparam logic [2:0] W_SBREF = 3'h6;
    localparam logic [AXI_AW-1:0] CTRL_ADDR = 12'h400;
    localparam logic [AXI_AW-1:0] STAT_ADDR = 12'h404;
    // Field positions
    localparam int ARR_LSB = 16;
    localparam int STRIDE_LSB = 16;
    localparam int REQUESTER_PRIVILEGE_LEVEL_BIT = 8;
    localparam int RUN_BIT = 0;
    localparam int BUSY_BIT = 16;
    // Reset values and responses
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b10
    } eng_state_type;
endpackage

// >>> hw/wctx_step.sv
// Next-state arithmetic for the active write context
`timescale 1ns/1ps
`default_nettype none
module wctx_step (
    // Current context
    input wire logic [15:0] bytes,
    input wire logic [15:0] arrays,
    input wire logic [31:0] addr,
    input wire logic [31:0] base,
    input wire logic [15:0] stride,
    input wire logic [15:0] reload,
    input wire logic [15:0] chunk,
    // Next context
    output logic [15:0] len,
    output logic [15:0] nbytes,
    output logic [15:0] narrays,
    output logic [31:0] naddr,
    output logic [31:0] nbase,
    output logic array_end,
    output logic last
);
    wire logic [31:0] next_base;
    assign len = (bytes > chunk) ? chunk : bytes;
    assign array_end = (bytes == len);
    assign last = array_end && (arrays <= 16'h0001);
    assign next_base = base + {16'h0000, stride};
    assign nbytes = array_end ? reload : bytes - len;
    assign narrays = array_end ? arrays - 16'h0001 : arrays;
    assign naddr = last ? addr : (array_end ? next_base : addr + {16'h0000, len});
    assign nbase = (array_end && !last) ? next_base : base;
endmodule // wctx_step
`default_nettype wire

// >>> verif/dma_write_context_status_tb.sv
// Self-checking bench for the write context status block
`timescale 1ns/1ps
`default_nettype none
module dma_write_context_status_tb;
    import wctx_pkg::*;
    localparam logic [15:0] CH = 16'h0040;
    logic aclk = 0, aresetn = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, sub_valid = 0, sub_requester_privilege_level = 0, cmd_ready = 0, wr_done = 0;
    logic [31:0] s_axi_wdata = 0, sub_addr = 0, s_axi_rdata, cmd_addr;
    logic [3:0] s_axi_wstrb = 4'hf, sub_host_id = 0, cmd_host_id;
    logic [15:0] sub_arrays = 0, sub_bytes = 0, sub_stride = 0, cmd_len;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic sub_ready, cmd_valid, cmd_requester_privilege_level, req_done;
    logic [4:0] e_tag;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    dma_write_context_status #(.DEPTH(4), .CHUNK(CH)) u_dma_write_context_status (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sub_valid, .sub_ready, .sub_arrays,
        .sub_bytes, .sub_addr, .sub_stride, .sub_requester_privilege_level, .sub_host_id, .cmd_valid,
        .cmd_ready, .cmd_addr, .cmd_len, .cmd_requester_privilege_level, .cmd_host_id, .wr_done, .req_done);
    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    // ****************************************
    // Bus and port tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 0;
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(nm, e, d);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ta, tw, pa, pw;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= d; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        pa = 1;
        pw = 1;
        // Track pending channels locally: valid itself only updates after this time step
        while (pa || pw) begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            @(posedge aclk);
            if (pa && ta) s_axi_awvalid <= 0;
            if (pw && tw) s_axi_wvalid <= 0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 0;
    endtask
    task automatic sub(input logic [15:0] na, nb, input logic [31:0] ad, input logic [15:0] st,
                       input logic pv, input logic [3:0] h);
        do @(negedge aclk); while (sub_ready !== 1'b1);
        @(posedge aclk);
        sub_valid <= 1; sub_arrays <= na; sub_bytes <= nb; sub_addr <= ad;
        sub_stride <= st; sub_requester_privilege_level <= pv; sub_host_id <= h;
        @(posedge aclk);
        sub_valid <= 0;
    endtask
    task automatic serve(input logic [31:0] ea, input logic [15:0] el, input bit last);
        bit seen;
        do @(negedge aclk); while (cmd_valid !== 1'b1);
        chk("cmd_addr", ea, cmd_addr);
        chk("cmd_len", el, cmd_len);
        chk("cmd_tag", e_tag, {cmd_requester_privilege_level, cmd_host_id});
        @(posedge aclk);
        cmd_ready <= 1;
        @(posedge aclk);
        cmd_ready <= 0; wr_done <= 1;
        @(posedge aclk);
        wr_done <= 0;
        seen = 0;
        if (last) begin
            repeat (4) begin
                @(negedge aclk);
                if (req_done === 1'b1) seen = 1;
            end
            chk("req_done", 1, seen);
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_fill();
        logic [1:0] r;
        wr(CTRL_ADDR, 0, r);
        for (int n = 0; n < 4; n++) sub(1, 4, 32'h2000 + n * 16, 0, n[0], n[3:0]);
        @(negedge aclk);
        chk("sub_ready full", 0, sub_ready);
        for (int n = 0; n < 4; n++) begin
            rc("proxy", n * 32 + 16, (n[0] << 8) | n);
            rc("counts", n * 32 + 4, 32'h0001_0004);
        end
        wr(CTRL_ADDR, 1, r);
        for (int n = 0; n < 4; n++) begin
            e_tag = {n[0], n[3:0]};
            serve(32'h2000 + n * 16, 4, 1);
        end
        $display("t_fill done");
    endtask
    task automatic t_xfer();
        logic [31:0] d;
        logic [1:0] r;
        wr(CTRL_ADDR, 0, r);
        rc("ctrl", CTRL_ADDR, 0);
        e_tag = 5'h11;
        sub(2, 16'h0050, 32'h1000, 16'h0100, 1, 1);
        rc("status", STAT_ADDR, 32'h0000_0001);
        rc("src", 12'h000, 0);
        rc("counts", 12'h004, 32'h0002_0050);
        rc("addr", 12'h008, 32'h1000);
        rc("stride", 12'h00c, 32'h0100_0000);
        rc("proxy", 12'h010, 32'h0101);
        rc("reload", 12'h014, 32'h0050);
        rc("src_ref", 12'h018, 0);
        rd(12'h01c, d, r);
        chk("unmapped resp", RESP_SLVERR, r);
        chk("unmapped data", 0, d);
        wr(12'h004, 32'hffff_ffff, r);
        chk("ro write resp", RESP_OKAY, r);
        rc("counts kept", 12'h004, 32'h0002_0050);
        wr(CTRL_ADDR, 1, r);
        serve(32'h1000, CH, 0);
        rc("counts mid", 12'h004, 32'h0002_0010);
        rc("addr mid", 12'h008, 32'h1040);
        serve(32'h1040, 16'h0010, 0);
        rc("counts next", 12'h004, 32'h0001_0050);
        rc("addr next", 12'h008, 32'h1100);
        serve(32'h1100, CH, 0);
        serve(32'h1140, 16'h0010, 1);
        rc("addr final", 12'h008, 32'h1140);
        $display("t_xfer done");
    endtask
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        t_fill();
        t_xfer();
        summarize();
    end
endmodule // dma_write_context_status_tb
`default_nettype wire
